// [hdl/acl_match.v]
// Access list entry store and priority match against one packet descriptor.
`timescale 1ns/1ps
`default_nettype none
`include "port_access_filter_consts.vh"
module acl_match #(
  parameter ENTRIES = 32,
  parameter IDX_W = 5
) (
  input wire core_clk,
  input wire srst,
  input wire wr_en,
  input wire [IDX_W-1:0] wr_idx,
  input wire [`ACTL_W-1:0] wr_ctrl,
  input wire [47:0] wr_smac,
  input wire [47:0] wr_dmac,
  input wire [31:0] wr_sip,
  input wire [47:0] src_mac,
  input wire [47:0] dst_mac,
  input wire [31:0] src_ip,
  input wire [3:0] in_port,
  output reg hit,
  output reg hit_drop,
  output reg [IDX_W-1:0] hit_idx
);
  reg [`ACTL_W-1:0] ctrl [0:ENTRIES-1];
  reg [47:0] smac [0:ENTRIES-1];
  reg [47:0] dmac [0:ENTRIES-1];
  reg [31:0] sip [0:ENTRIES-1];
  wire [ENTRIES-1:0] match;
  integer k;
  // ============================================================
  // Entry store
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : entry
      always @(posedge core_clk) begin
        if (srst) begin
          ctrl[g] <= `ACTL_RESET;
        end else if (wr_en && wr_idx == g) begin
          ctrl[g] <= wr_ctrl;
          smac[g] <= wr_smac;
          dmac[g] <= wr_dmac;
          sip[g] <= wr_sip;
        end
      end
      assign match[g] = ctrl[g][`ACTL_VALID] &&
        (ctrl[g][`ACTL_SMAC_ANY] || smac[g] == src_mac) &&
        (ctrl[g][`ACTL_DMAC_ANY] || dmac[g] == dst_mac) &&
        (ctrl[g][`ACTL_SIP_ANY] || sip[g] == src_ip) &&
        (ctrl[g][`ACTL_PORT_ANY] || ctrl[g][`ACTL_PORT_MSB:`ACTL_PORT_LSB] == in_port);
    end
  endgenerate
  // ============================================================
  // Priority resolution: the lowest index wins, so later overlapping entries never override it.
  always @* begin
    hit = 1'b0;
    hit_drop = 1'b0;
    hit_idx = {IDX_W{1'b0}};
    for (k = ENTRIES - 1; k >= 0; k = k - 1) begin
      if (match[k]) begin
        hit = 1'b1;
        hit_drop = ctrl[k][`ACTL_DROP];
        hit_idx = k[IDX_W-1:0];
      end
    end
  end
endmodule // acl_match
`default_nettype wire

// [hdl/port_access_filter.v]
// Port access filter: per-port authentication gating, access list deny and Avalon-MM registers.
// Functional notes
// - Direction both and unauthenticated: drop received and transmitted packets of the port.
// - Direction inbound and unauthenticated: drop received packets, still transmit outgoing ones.
// - Auto mode: port passes traffic only after its user is authenticated.
// - Forced-authorized mode: port always counts as authenticated.
// - Forced-unauthorized mode: no packet passes the port in either direction.
// - Reauthentication enabled: authorized port loses authorization at each interval end; the code times only auto-mode ports while global enable is set.
// - Reauthentication interval per port, 0 to 65535 seconds, reset value 3600.
// - Port gating acts only while global enable is set; agent sets it first.
// - Per-port status readable: enable, direction, mode, reauth enable, interval.
// - Access list entry applies to one ingress port or to all ports.
// - Packet source and destination MAC compared against access list entries.
// - Up to 32 entries; matching packets get the action set by the entry's drop flag.
// - Several hits: action and counters from the highest-priority entry only.
// - Entry drop flag: discard when set, leave packet untouched when clear.
// - Source MAC criterion is wildcard or one exact address.
// - Source IP criterion is wildcard or one exact address.
// - Source interface criterion is wildcard or one port 1 to 10.
// - Timer defaults: two retries, quiet 20 s, supplicant 30 s, server 16 s.
`timescale 1ns/1ps
`default_nettype none
`include "port_access_filter_consts.vh"
module port_access_filter #(
  parameter PORTS = `NUM_PORTS,
  parameter ENTRIES = 32,
  parameter IDX_W = 5,
  parameter SEC_CYCLES = `SEC_NS / `CLK_PERIOD_NS
) (
  input wire core_clk,
  input wire srst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire pkt_valid,
  input wire [47:0] pkt_src_mac,
  input wire [47:0] pkt_dst_mac,
  input wire [31:0] pkt_src_ip,
  input wire [3:0] pkt_in_port,
  input wire [3:0] pkt_out_port,
  output reg res_valid,
  output reg res_drop,
  output reg res_acl_hit
);
  // ============================================================
  // Register state
  reg global_en;
  reg [PORTS-1:0] authorized;
  reg [47:0] stg_smac;
  reg [47:0] stg_dmac;
  reg [31:0] stg_sip;
  reg [`ACTL_W-1:0] stg_ctrl;
  reg [31:0] drop_cnt;
  reg last_hit_valid;
  reg [IDX_W-1:0] last_hit_idx;
  reg [`PCFG_W-1:0] pcfg [0:PORTS-1];
  reg [15:0] sec_cnt [0:PORTS-1];
  reg [27:0] tick_div;
  reg sec_tick;
  reg [31:0] next_readdata;
  wire bus_req = avs_read || avs_write;
  wire wr_acc = avs_write && !avs_waitrequest;
  wire port_sel = avs_address >= `REG_PORT_BASE && avs_address <= `REG_PORT_LAST;
  wire [7:0] port_off = avs_address - `REG_PORT_BASE;
  wire [3:0] port_idx = port_off[5:2];
  wire acl_wr = wr_acc && avs_address == `REG_ACL_COMMIT;
  wire [PORTS-1:0] expire;
  wire [PORTS-1:0] eff_auth;
  wire [PORTS-1:0] both_dir;
  wire acl_hit;
  wire acl_hit_drop;
  wire [IDX_W-1:0] acl_idx;

  // ============================================================
  // Bus slave: one wait cycle, then the request is accepted with data registered.
  always @(posedge core_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= avs_read ? next_readdata : 32'h00000000;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always @* begin
    next_readdata = 32'h00000000;
    if (port_sel) begin
      if (port_idx < PORTS) begin
        next_readdata = {11'h000, global_en, pcfg[port_idx]};
      end
    end else begin
      case (avs_address)
        `REG_GLOBAL: next_readdata = {31'h00000000, global_en};
        `REG_AUTH: next_readdata = {{(32-PORTS){1'b0}}, authorized};
        `REG_TIMER_DEF: next_readdata = `TIMER_DEFAULTS;
        `REG_SMAC_LO: next_readdata = stg_smac[31:0];
        `REG_SMAC_HI: next_readdata = {16'h0000, stg_smac[47:32]};
        `REG_DMAC_LO: next_readdata = stg_dmac[31:0];
        `REG_DMAC_HI: next_readdata = {16'h0000, stg_dmac[47:32]};
        `REG_SIP: next_readdata = stg_sip;
        `REG_ACL_CTRL: next_readdata = {22'h000000, stg_ctrl};
        `REG_DROP_CNT: next_readdata = drop_cnt;
        `REG_LAST_HIT: next_readdata = {26'h0000000, last_hit_valid, last_hit_idx};
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  // ============================================================
  // Global and staging registers
  always @(posedge core_clk) begin
    if (srst) begin
      global_en <= 1'b0;
      stg_smac <= 48'h000000000000;
      stg_dmac <= 48'h000000000000;
      stg_sip <= 32'h00000000;
      stg_ctrl <= `ACTL_RESET;
    end else if (wr_acc) begin
      case (avs_address)
        `REG_GLOBAL: global_en <= avs_writedata[0];
        `REG_SMAC_LO: stg_smac[31:0] <= avs_writedata;
        `REG_SMAC_HI: stg_smac[47:32] <= avs_writedata[15:0];
        `REG_DMAC_LO: stg_dmac[31:0] <= avs_writedata;
        `REG_DMAC_HI: stg_dmac[47:32] <= avs_writedata[15:0];
        `REG_SIP: stg_sip <= avs_writedata;
        `REG_ACL_CTRL: stg_ctrl <= avs_writedata[`ACTL_W-1:0];
        default: global_en <= global_en;
      endcase
    end
  end

  // ============================================================
  // One-second tick for the reauthentication interval.
  always @(posedge core_clk) begin
    if (srst) begin
      tick_div <= 28'h0000000;
      sec_tick <= 1'b0;
    end else if (tick_div == SEC_CYCLES - 1) begin
      tick_div <= 28'h0000000;
      sec_tick <= 1'b1;
    end else begin
      tick_div <= tick_div + 28'h0000001;
      sec_tick <= 1'b0;
    end
  end

  // ============================================================
  // Per-port configuration, reauthentication timer and gating terms
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : port
      wire [1:0] mode = pcfg[p][`PCFG_MODE_MSB:`PCFG_MODE_LSB];
      wire timing = global_en && mode == `MODE_AUTO && pcfg[p][`PCFG_REAUTH_BIT] && authorized[p];
      always @(posedge core_clk) begin
        if (srst) begin
          pcfg[p] <= `PCFG_RESET;
        end else if (wr_acc && port_sel && port_idx == p) begin
          pcfg[p] <= avs_writedata[`PCFG_W-1:0];
        end
      end
      // The counter restarts whenever the port is not being timed, so a fresh login gets a full interval.
      always @(posedge core_clk) begin
        if (srst || !timing || expire[p]) begin
          sec_cnt[p] <= 16'h0000;
        end else if (sec_tick) begin
          sec_cnt[p] <= sec_cnt[p] + 16'h0001;
        end
      end
      assign expire[p] = timing && sec_tick &&
        ({1'b0, sec_cnt[p]} + 17'h00001 >= {1'b0, pcfg[p][`PCFG_PERIOD_MSB:0]});
      assign eff_auth[p] = mode == `MODE_FORCE_AUTH ? 1'b1 :
        mode == `MODE_FORCE_UNAUTH ? 1'b0 :
        authorized[p];
      assign both_dir[p] = pcfg[p][`PCFG_DIR_BIT] == `DIR_BOTH || mode == `MODE_FORCE_UNAUTH;
    end
  endgenerate

  // Authorization comes from the agent; an agent write in the same cycle as an expiry wins.
  always @(posedge core_clk) begin
    if (srst) begin
      authorized <= {PORTS{1'b0}};
    end else if (wr_acc && avs_address == `REG_AUTH) begin
      authorized <= avs_writedata[PORTS-1:0];
    end else begin
      authorized <= authorized & ~expire;
    end
  end

  // ============================================================
  // Access list
  acl_match #(
    .ENTRIES(ENTRIES),
    .IDX_W(IDX_W)
  ) acl (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(acl_wr),
    .wr_idx(avs_writedata[IDX_W-1:0]),
    .wr_ctrl(stg_ctrl),
    .wr_smac(stg_smac),
    .wr_dmac(stg_dmac),
    .wr_sip(stg_sip),
    .src_mac(pkt_src_mac),
    .dst_mac(pkt_dst_mac),
    .src_ip(pkt_src_ip),
    .in_port(pkt_in_port),
    .hit(acl_hit),
    .hit_drop(acl_hit_drop),
    .hit_idx(acl_idx)
  );

  // ============================================================
  // Packet decision: one verdict per descriptor, applied by the port to the whole frame.
  wire in_ok = pkt_in_port >= 4'h1 && pkt_in_port <= PORTS;
  wire out_ok = pkt_out_port >= 4'h1 && pkt_out_port <= PORTS;
  wire [3:0] in_i = pkt_in_port - 4'h1;
  wire [3:0] out_i = pkt_out_port - 4'h1;
  wire in_drop = global_en && in_ok && !eff_auth[in_i];
  wire out_drop = global_en && out_ok && !eff_auth[out_i] && both_dir[out_i];
  wire acl_drop = acl_hit && acl_hit_drop;

  always @(posedge core_clk) begin
    if (srst) begin
      res_valid <= 1'b0;
      res_drop <= 1'b0;
      res_acl_hit <= 1'b0;
      drop_cnt <= 32'h00000000;
      last_hit_valid <= 1'b0;
      last_hit_idx <= {IDX_W{1'b0}};
    end else begin
      res_valid <= pkt_valid;
      res_drop <= pkt_valid && (in_drop || out_drop || acl_drop);
      res_acl_hit <= pkt_valid && acl_hit;
      if (pkt_valid && acl_hit) begin
        last_hit_valid <= 1'b1;
        last_hit_idx <= acl_idx;
      end
      if (wr_acc && avs_address == `REG_DROP_CNT) begin
        drop_cnt <= 32'h00000000;
      end else if (pkt_valid && (in_drop || out_drop || acl_drop)) begin
        drop_cnt <= drop_cnt + 32'h00000001;
      end
    end
  end
endmodule // port_access_filter
`default_nettype wire

// [shared/port_access_filter_consts.vh]
// Constants for the port access filter: register map, field positions, reset values, timing.
`ifndef PORT_ACCESS_FILTER_CONSTS_VH
`define PORT_ACCESS_FILTER_CONSTS_VH
// ============================================================
// Register byte addresses
`define REG_GLOBAL 8'h00
`define REG_AUTH 8'h04
`define REG_TIMER_DEF 8'h08
`define REG_SMAC_LO 8'h10
`define REG_SMAC_HI 8'h14
`define REG_DMAC_LO 8'h18
`define REG_DMAC_HI 8'h1C
`define REG_SIP 8'h20
`define REG_ACL_CTRL 8'h24
`define REG_ACL_COMMIT 8'h28
`define REG_DROP_CNT 8'h2C
`define REG_LAST_HIT 8'h30
`define REG_PORT_BASE 8'h40
`define REG_PORT_LAST 8'h64
// ============================================================
// Port configuration fields
`define PCFG_PERIOD_MSB 15
`define PCFG_DIR_BIT 16
`define PCFG_MODE_LSB 17
`define PCFG_MODE_MSB 18
`define PCFG_REAUTH_BIT 19
`define PCFG_GLOBAL_BIT 20
`define PCFG_W 20
`define PCFG_RESET 20'h00E10
`define DIR_BOTH 1'b0
`define DIR_IN 1'b1
`define MODE_AUTO 2'h0
`define MODE_FORCE_AUTH 2'h1
`define MODE_FORCE_UNAUTH 2'h2
// ============================================================
// Access list control fields
`define ACTL_DROP 0
`define ACTL_SMAC_ANY 1
`define ACTL_DMAC_ANY 2
`define ACTL_SIP_ANY 3
`define ACTL_PORT_ANY 4
`define ACTL_PORT_LSB 5
`define ACTL_PORT_MSB 8
`define ACTL_VALID 9
`define ACTL_W 10
`define ACTL_RESET 10'h01E
// ============================================================
// Authentication timer defaults: retries, quiet, supplicant, server (seconds)
`define TIMER_DEFAULTS 32'h02141E10
// ============================================================
// Timing
`define SEC_NS 1000000000
`define CLK_PERIOD_NS 5
`define NUM_PORTS 10
`endif

// [verification/pkt_side.sv]
// Switch port side model presenting one packet descriptor per call.
`timescale 1ns/1ps
`default_nettype none
module pkt_side (
  input wire logic core_clk,
  output logic pkt_valid = 1'b0,
  output logic [47:0] pkt_src_mac = 48'h0,
  output logic [47:0] pkt_dst_mac = 48'h0,
  output logic [31:0] pkt_src_ip = 32'h0,
  output logic [3:0] pkt_in_port = 4'h0,
  output logic [3:0] pkt_out_port = 4'h0
);
  task send(input logic [47:0] sm, input logic [47:0] dm, input logic [31:0] ip, input logic [3:0] i,
            input logic [3:0] o);
    @(posedge core_clk);
    pkt_valid <= 1'b1;
    pkt_src_mac <= sm;
    pkt_dst_mac <= dm;
    pkt_src_ip <= ip;
    pkt_in_port <= i;
    pkt_out_port <= o;
    @(posedge core_clk);
    pkt_valid <= 1'b0;
    // Idle MAC and IP fields flip so a stale descriptor can never pass for a live one.
    pkt_src_mac <= ~sm;
    pkt_dst_mac <= ~dm;
    pkt_src_ip <= ~ip;
  endtask
endmodule // pkt_side
`default_nettype wire

// [verification/port_access_filter_asserts.sv]
// Port-level checker for the port access filter.
`timescale 1ns/1ps
`default_nettype none
`include "port_access_filter_consts.vh"
module port_access_filter_asserts (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pkt_valid,
  input wire logic res_valid,
  input wire logic res_drop,
  input wire logic res_acl_hit
);
  // ==========
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  res_timing_a: assert property (pkt_valid |=> res_valid) else $error("result missing");
  res_cause_a: assert property (res_valid |-> $past(pkt_valid)) else $error("stray result");
  drop_qual_a: assert property (res_drop |-> res_valid) else $error("drop without result");
  hit_qual_a: assert property (res_acl_hit |-> res_valid) else $error("hit without result");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low twice");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |-> ##[0:3] !avs_waitrequest)
    else $error("bus answer late");
  no_spur_a: assert property (!avs_waitrequest |-> avs_read || avs_write) else $error("spurious answer");
  timer_ro_a: assert property (avs_read && !avs_waitrequest && avs_address == `REG_TIMER_DEF
    |-> avs_readdata == `TIMER_DEFAULTS) else $error("timer defaults wrong");
  rst_idle_a: assert property (@(posedge core_clk) disable iff (1'b0)
    srst |=> avs_waitrequest && !res_valid) else $error("not idle after reset");
  // ==========
  // Covers
  cover property (res_valid && res_drop);
  cover property (res_valid && res_acl_hit && !res_drop);
  cover property (avs_write && !avs_waitrequest);
  cover property (res_valid && !res_drop && !res_acl_hit);
endmodule // port_access_filter_asserts
bind port_access_filter port_access_filter_asserts chk (.core_clk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .pkt_valid, .res_valid, .res_drop, .res_acl_hit);
`default_nettype wire

// [verification/test_port_access_filter.sv]
// Self-checking testbench for the port access filter.
`timescale 1ns/1ps
`default_nettype none
`include "port_access_filter_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module test_port_access_filter;
  logic core_clk, srst, avs_read, avs_write, avs_waitrequest, res_valid, res_drop, res_acl_hit, pkt_valid;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rq, pkt_src_ip;
  logic [47:0] pkt_src_mac, pkt_dst_mac;
  logic [3:0] pkt_in_port, pkt_out_port;
  logic [1:0] expq[$];
  logic [1:0] note;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'h88E8288B;
  localparam logic [47:0] MX = 48'h0A1B2C3D4E5F;
  localparam logic [47:0] MW = 48'h0600DDEE0011;
  localparam logic [31:0] IY = 32'hC0A80A05;
  port_access_filter #(.SEC_CYCLES(20)) dut (.core_clk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .pkt_valid, .pkt_src_mac, .pkt_dst_mac, .pkt_src_ip,
    .pkt_in_port, .pkt_out_port, .res_valid, .res_drop, .res_acl_hit);
  pkt_side src (.core_clk, .pkt_valid, .pkt_src_mac, .pkt_dst_mac, .pkt_src_ip, .pkt_in_port, .pkt_out_port);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ==========
  // Tasks
  task close_out;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task rd(input logic [7:0] a); bus(1'b0, a, 32'h0); endtask
  function logic [47:0] r48(); return {16'($random(seed)), 32'($random(seed))}; endfunction
  task pkt(input logic [47:0] sm, dm, input logic [31:0] ip, input logic [3:0] i, o, input logic d, h);
    expq.push_back({d, h});
    src.send(sm, dm, ip, i, o);
  endtask
  task entry(input logic [4:0] ix, input logic [47:0] sm, dm, input logic [31:0] ip, input logic [9:0] c);
    wr(`REG_SMAC_LO, sm[31:0]);
    wr(`REG_SMAC_HI, {16'h0, sm[47:32]});
    wr(`REG_DMAC_LO, dm[31:0]);
    wr(`REG_DMAC_HI, {16'h0, dm[47:32]});
    wr(`REG_SIP, ip);
    wr(`REG_ACL_CTRL, {22'h0, c});
    wr(`REG_ACL_COMMIT, {27'h0, ix});
  endtask
  // ==========
  // Result watcher and watchdog
  always @(posedge core_clk) begin
    if (res_valid === 1'b1) begin
      if (expq.size() == 0) begin
        num_errors++;
        $display("[FAIL] %0t result without packet", $time);
      end else begin
        note = expq.pop_front();
        `CHK({res_drop, res_acl_hit}, note)
      end
    end
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end
  // ==========
  // Tests
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rd(`REG_PORT_BASE); `CHK(rq, 32'h00000E10)
    rd(`REG_TIMER_DEF); `CHK(rq, `TIMER_DEFAULTS)
    rd(`REG_AUTH); `CHK(rq, 32'h0)
    rd(8'hFC); `CHK(rq, 32'h0)
    pkt(r48(), r48(), $random(seed), 4'h1, 4'h2, 1'b0, 1'b0);
    $display("reset and idle test done");
    wr(`REG_GLOBAL, 32'h1);
    rd(`REG_GLOBAL); `CHK(rq, 32'h1)
    rd(`REG_PORT_BASE); `CHK(rq, 32'h00100E10)
    rd(`REG_PORT_LAST); `CHK(rq, 32'h00100E10)
    rd(8'h68); `CHK(rq, 32'h0)
    pkt(r48(), r48(), $random(seed), 4'h1, 4'hB, 1'b1, 1'b0);
    wr(`REG_AUTH, 32'h2);
    pkt(r48(), r48(), $random(seed), 4'h2, 4'h1, 1'b1, 1'b0);
    pkt(r48(), r48(), $random(seed), 4'h2, 4'hB, 1'b0, 1'b0);
    wr(`REG_PORT_BASE, 32'h00010E10);
    rd(`REG_PORT_BASE); `CHK(rq, 32'h00110E10)
    pkt(r48(), r48(), $random(seed), 4'h2, 4'h1, 1'b0, 1'b0);
    pkt(r48(), r48(), $random(seed), 4'h1, 4'h2, 1'b1, 1'b0);
    wr(8'h48, 32'h00020E10);
    pkt(r48(), r48(), $random(seed), 4'h3, 4'h2, 1'b0, 1'b0);
    wr(8'h48, 32'h00040E10);
    wr(`REG_AUTH, 32'h6);
    pkt(r48(), r48(), $random(seed), 4'h3, 4'hB, 1'b1, 1'b0);
    pkt(r48(), r48(), $random(seed), 4'h2, 4'h3, 1'b1, 1'b0);
    // Mode code 3 behaves as auto, so an unauthorized port 4 still drops.
    wr(8'h4C, 32'h00060E10);
    pkt(r48(), r48(), $random(seed), 4'h4, 4'hB, 1'b1, 1'b0);
    $display("gating test done");
    // Period 2 at 20 cycles a second expires within about 40 cycles.
    wr(8'h44, 32'h00080002);
    repeat (100) @(posedge core_clk);
    rd(`REG_AUTH); `CHK(rq, 32'h4)
    $display("reauth test done");
    wr(`REG_GLOBAL, 32'h0);
    wr(`REG_DROP_CNT, 32'h0);
    entry(5'd0, MX, 48'h0, 32'h0, 10'h21D);
    entry(5'd1, 48'h0, 48'h0, IY, 10'h2A6);
    entry(5'd31, 48'h0, MW, 32'h0, 10'h21B);
    rd(`REG_ACL_CTRL); `CHK(rq, 32'h0000021B)
    rd(`REG_DMAC_HI); `CHK(rq, 32'h00000600)
    pkt(MX, r48(), $random(seed), 4'h4, 4'hB, 1'b1, 1'b1);
    pkt(r48(), r48(), IY, 4'h5, 4'hB, 1'b0, 1'b1);
    pkt(r48(), r48(), $random(seed), 4'h5, 4'hB, 1'b0, 1'b0);
    pkt(r48(), r48(), IY, 4'h6, 4'hB, 1'b0, 1'b0);
    pkt(MX, r48(), IY, 4'h5, 4'hB, 1'b1, 1'b1);
    rd(`REG_LAST_HIT); `CHK(rq, 32'h20)
    pkt(r48(), MW, $random(seed), 4'h2, 4'hB, 1'b1, 1'b1);
    rd(`REG_LAST_HIT); `CHK(rq, 32'h3F)
    rd(`REG_DROP_CNT); `CHK(rq, 32'h3)
    $display("access list test done");
    repeat (4) @(posedge core_clk);
    `CHK(expq.size(), 0)
    close_out();
  end
endmodule // test_port_access_filter
`default_nettype wire
